// ---- rtl/sisb_defs.svh ----
// Purpose: Offsets, bit positions, reset values and timing for the
//          interrupt status bank.
// Assumes: 8-bit registers on an 8-bit address, 200 MHz clock.
// Notes:   Definitions only.
`ifndef SISB_DEFS_SVH
`define SISB_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SISB_OFF_GLOBAL      8'h60
`define SISB_OFF_SYS         8'h61
`define SISB_OFF_SUP         8'h62
`define SISB_OFF_TRX         8'h63
`define SISB_OFF_IO0         8'h64
`define SISB_OFF_SYS_MASK    8'h70
`define SISB_OFF_SUP_MASK    8'h71
`define SISB_OFF_TRX_MASK    8'h72
`define SISB_OFF_IO0_MASK    8'h73

// ****************************************************************
// Field positions
// ****************************************************************
`define SISB_SUM_SYS_BIT     0
`define SISB_SUM_SUP_BIT     1
`define SISB_SUM_TRX_BIT     2
`define SISB_SUM_B0W_BIT     3
`define SISB_SUM_B0F_BIT     4
`define SISB_SUM_B1W_BIT     5
`define SISB_SUM_B1F_BIT     6
`define SISB_SYS_WD_BIT      0
`define SISB_SYS_PWRON_BIT   4
`define SISB_SUP_REGCHG_BIT  5
`define SISB_TRX_SILENCE_BIT 4
`define SISB_TRX_LIN2_BIT    3

// ****************************************************************
// Implemented bits, always-enabled sources, reset values
// ****************************************************************
`define SISB_SYS_IMPL        8'h37
`define SISB_SUP_IMPL        8'h3f
`define SISB_TRX_IMPL        8'h3f
`define SISB_IO0_IMPL        8'hff
`define SISB_SYS_ALWAYS      8'h31
`define SISB_FLAGS_RST       8'h00
`define SISB_MASK_RST        8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SISB_CLK_PERIOD_NS   5
`define SISB_SILENCE_TIME_US 1000

`endif

// ---- rtl/sisb_pkg.sv ----
// Purpose: Types shared by the interrupt status bank.
// Assumes: Constants come from sisb_defs.svh.
// Notes:   Raw event pulses arrive grouped per status register.
package sisb_pkg;

	// ****************************************************************
	// Register port request
	// ****************************************************************
	typedef struct packed {
		logic [7:0] addr;  // Register offset
		logic [7:0] wdata; // Write data
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
	} sisb_bus_req_s;

	// ****************************************************************
	// One-cycle event pulses, one per flag position
	// ****************************************************************
	typedef struct packed {
		logic [7:0] sys_evt; // System sources
		logic [7:0] sup_evt; // Supply sources
		logic [7:0] trx_evt; // Transceiver sources
		logic [7:0] io0_evt; // Bank-0 pin edges
	} sisb_events_s;

endpackage : sisb_pkg

// ---- rtl/sisb_flag_bank.sv ----
// Purpose: Eight sticky flags, set by hardware, cleared by writing one.
// Assumes: set_vec and clr_vec are one-cycle vectors.
// Notes:   Bits outside IMPL are tied to zero.
`timescale 1ns/100ps
module sisb_flag_bank #(
	parameter logic [7:0] IMPL = 8'hff
) (
	input  wire logic       sys_clk, // Clock
	input  wire logic       rst,     // Async reset
	input  wire logic [7:0] set_vec, // Hardware set
	input  wire logic [7:0] clr_vec, // Software clear
	output logic      [7:0] flags    // Flag state
);
	genvar i;

	// ****************************************************************
	// One flop per implemented bit
	// ****************************************************************
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			if (IMPL[i]) begin : g_impl
				always_ff @(posedge sys_clk or posedge rst) begin
					if (rst)
						flags[i] <= 1'b0;
					else if (set_vec[i])
						flags[i] <= 1'b1; // R13
					else if (clr_vec[i])
						flags[i] <= 1'b0; // R13
				end
			end else begin : g_rsvd
				assign flags[i] = 1'b0;
			end
		end
	endgenerate

endmodule : sisb_flag_bank

// ---- rtl/sisb_top.sv ----
// Purpose: Pending-flag collection and summary for a basis chip.
// Assumes: Event inputs are one-cycle pulses synchronous to sys_clk.
// Notes:   Enable masks gate the interrupt only, never the flags.
//
// Functional notes
// R1: summary bits 0-2 show system/supply/transceiver pending
// R2: summary bits 3-6 show bank wake/fail pending
// R3: summary register read-only, bit 7 reserved
// R4: system flags at bits 5,4,2,1,0
// R5: supply flags at bits 5..0
// R6: regulator change flag on switcher bit change
// R7: transceiver flags at bits 5..0
// R8: silence flag after bus silent past timeout
// R9: single-LIN build reserves second wake bit
// R10: pin n rising at even, falling odd
// R11: power-on flag on leaving off, unmaskable
// R12: watchdog overflow while pending forces reset
// R13: write one clears; new event sets again
// R14: interrupt while any enabled flag pending
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "sisb_defs.svh"
module sisb_top
	import sisb_pkg::*;
#(
	parameter int LIN_COUNT      = 2,
	parameter int SILENCE_CYCLES =
		`SISB_SILENCE_TIME_US * 1000 / `SISB_CLK_PERIOD_NS
) (
	input  wire logic          sys_clk,       // 200 MHz clock
	input  wire logic          rst,           // Async reset, high
	input  wire sisb_bus_req_s bus,           // Register request
	output logic         [7:0] rd_data,       // Read data, next cycle
	input  wire sisb_events_s  events,        // Raw event pulses
	input  wire logic          off_exit,      // Left off state, pulse
	input  wire logic          wd_overflow,   // Watchdog overflow
	input  wire logic          switcher_state_bit, // Regulator state
	input  wire logic          can_bus_silent, // Bus idle level
	input  wire logic          bank0_fail_pend, // Bank-0 fail pending
	input  wire logic          bank1_wake_pend, // Bank-1 wake pending
	input  wire logic          bank1_fail_pend, // Bank-1 fail pending
	output logic               wd_reset_req,  // Reset request pulse
	output logic               irq            // Interrupt level
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam logic [17:0] SIL_LIM = 18'(SILENCE_CYCLES);
	localparam logic [7:0]  TRX_IMPL = (LIN_COUNT > 1) ?
		`SISB_TRX_IMPL :
		(`SISB_TRX_IMPL & ~(8'h01 << `SISB_TRX_LIN2_BIT));

	logic [7:0]  sys_flags;
	logic [7:0]  sup_flags;
	logic [7:0]  trx_flags;
	logic [7:0]  io0_flags;
	logic [7:0]  sys_set;
	logic [7:0]  sup_set;
	logic [7:0]  trx_set;
	logic [7:0]  io0_set;
	logic [7:0]  sys_clr;
	logic [7:0]  sup_clr;
	logic [7:0]  trx_clr;
	logic [7:0]  io0_clr;
	logic [7:0]  sys_mask_reg;
	logic [7:0]  sup_mask_reg;
	logic [7:0]  trx_mask_reg;
	logic [7:0]  io0_mask_reg;
	logic [7:0]  global_sum;
	logic [7:0]  rd_next;
	logic [7:0]  rd_data_reg;
	logic        sw_prev_reg;
	logic        sw_seen_reg;
	logic        regchg_evt;
	logic [17:0] sil_cnt_reg;
	logic        silence_evt;
	logic        wd_set;
	logic        wd_reset_reg;
	logic        wr_sys;
	logic        wr_sup;
	logic        wr_trx;
	logic        wr_io0;

	// ****************************************************************
	// Write decode
	// ****************************************************************
	assign wr_sys = bus.wr && (bus.addr == `SISB_OFF_SYS);
	assign wr_sup = bus.wr && (bus.addr == `SISB_OFF_SUP);
	assign wr_trx = bus.wr && (bus.addr == `SISB_OFF_TRX);
	assign wr_io0 = bus.wr && (bus.addr == `SISB_OFF_IO0);

	// Writing one clears; zero bits leave the flag alone
	assign sys_clr = wr_sys ? bus.wdata : 8'h00; // R13
	assign sup_clr = wr_sup ? bus.wdata : 8'h00; // R13
	assign trx_clr = wr_trx ? bus.wdata : 8'h00; // R13
	assign io0_clr = wr_io0 ? bus.wdata : 8'h00; // R13

	// ****************************************************************
	// Regulator state change detect
	// ****************************************************************
	// No reference value exists until the first sampled cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sw_prev_reg <= 1'b0;
			sw_seen_reg <= 1'b0;
		end else begin
			sw_prev_reg <= switcher_state_bit;
			sw_seen_reg <= 1'b1;
		end
	end

	assign regchg_evt = sw_seen_reg &&
		(switcher_state_bit != sw_prev_reg); // R6

	// ****************************************************************
	// Bus silence timer
	// ****************************************************************
	// Counter parks one past the limit so the event fires once per
	// silent stretch
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			sil_cnt_reg <= 18'h00000;
		else if (!can_bus_silent)
			sil_cnt_reg <= 18'h00000;
		else if (sil_cnt_reg != SIL_LIM + 18'h00001)
			sil_cnt_reg <= sil_cnt_reg + 18'h00001;
	end

	assign silence_evt = can_bus_silent && (sil_cnt_reg == SIL_LIM); // R8

	// ****************************************************************
	// Watchdog escalation
	// ****************************************************************
	// A second overflow while pending does not touch the flag
	assign wd_set = wd_overflow && !sys_flags[`SISB_SYS_WD_BIT]; // R12

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			wd_reset_reg <= 1'b0;
		else
			wd_reset_reg <= wd_overflow &&
				sys_flags[`SISB_SYS_WD_BIT]; // R12
	end

	assign wd_reset_req = wd_reset_reg;

	// ****************************************************************
	// Set vectors
	// ****************************************************************
	always_comb begin
		sys_set = events.sys_evt & `SISB_SYS_IMPL; // R4
		sys_set[`SISB_SYS_WD_BIT]    = wd_set;
		sys_set[`SISB_SYS_PWRON_BIT] = off_exit; // R11
		sup_set = events.sup_evt & `SISB_SUP_IMPL; // R5
		sup_set[`SISB_SUP_REGCHG_BIT] = regchg_evt; // R6
		trx_set = events.trx_evt & TRX_IMPL; // R7 R9
		trx_set[`SISB_TRX_SILENCE_BIT] = silence_evt; // R8
		io0_set = events.io0_evt & `SISB_IO0_IMPL; // R10
	end

	// ****************************************************************
	// Flag registers
	// ****************************************************************
	sisb_flag_bank #(
		.IMPL    (`SISB_SYS_IMPL)
	) u_sys (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set_vec (sys_set),
		.clr_vec (sys_clr),
		.flags   (sys_flags)
	);

	sisb_flag_bank #(
		.IMPL    (`SISB_SUP_IMPL)
	) u_sup (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set_vec (sup_set),
		.clr_vec (sup_clr),
		.flags   (sup_flags)
	);

	sisb_flag_bank #(
		.IMPL    (TRX_IMPL)
	) u_trx (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set_vec (trx_set),
		.clr_vec (trx_clr),
		.flags   (trx_flags)
	);

	sisb_flag_bank #(
		.IMPL    (`SISB_IO0_IMPL)
	) u_io0 (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set_vec (io0_set),
		.clr_vec (io0_clr),
		.flags   (io0_flags)
	);

	// ****************************************************************
	// Enable masks
	// ****************************************************************
	// Always-enabled system sources hold no mask bit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sys_mask_reg <= `SISB_MASK_RST;
			sup_mask_reg <= `SISB_MASK_RST;
			trx_mask_reg <= `SISB_MASK_RST;
			io0_mask_reg <= `SISB_MASK_RST;
		end else if (bus.wr) begin
			case (bus.addr)
				`SISB_OFF_SYS_MASK: sys_mask_reg <= bus.wdata &
					`SISB_SYS_IMPL & ~`SISB_SYS_ALWAYS;
				`SISB_OFF_SUP_MASK: sup_mask_reg <= bus.wdata &
					`SISB_SUP_IMPL;
				`SISB_OFF_TRX_MASK: trx_mask_reg <= bus.wdata & TRX_IMPL;
				`SISB_OFF_IO0_MASK: io0_mask_reg <= bus.wdata &
					`SISB_IO0_IMPL;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Interrupt output
	// ****************************************************************
	assign irq =
		|(sys_flags & (sys_mask_reg | `SISB_SYS_ALWAYS)) | // R11 R14
		|(sup_flags & sup_mask_reg) |
		|(trx_flags & trx_mask_reg) |
		|(io0_flags & io0_mask_reg); // R14

	// ****************************************************************
	// Global summary
	// ****************************************************************
	// Built from flag state and the bank pending inputs; nothing software writes lands here
	always_comb begin
		global_sum = 8'h00; // R3
		global_sum[`SISB_SUM_SYS_BIT] = |sys_flags; // R1
		global_sum[`SISB_SUM_SUP_BIT] = |sup_flags; // R1
		global_sum[`SISB_SUM_TRX_BIT] = |trx_flags; // R1
		global_sum[`SISB_SUM_B0W_BIT] = |io0_flags; // R2
		global_sum[`SISB_SUM_B0F_BIT] = bank0_fail_pend; // R2
		global_sum[`SISB_SUM_B1W_BIT] = bank1_wake_pend; // R2
		global_sum[`SISB_SUM_B1F_BIT] = bank1_fail_pend; // R2
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always_comb begin
		case (bus.addr)
			`SISB_OFF_GLOBAL:   rd_next = global_sum;
			`SISB_OFF_SYS:      rd_next = sys_flags;
			`SISB_OFF_SUP:      rd_next = sup_flags;
			`SISB_OFF_TRX:      rd_next = trx_flags;
			`SISB_OFF_IO0:      rd_next = io0_flags;
			`SISB_OFF_SYS_MASK: rd_next = sys_mask_reg;
			`SISB_OFF_SUP_MASK: rd_next = sup_mask_reg;
			`SISB_OFF_TRX_MASK: rd_next = trx_mask_reg;
			`SISB_OFF_IO0_MASK: rd_next = io0_mask_reg;
			default:            rd_next = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rd_data_reg <= 8'h00;
		else if (bus.rd)
			rd_data_reg <= rd_next;
		else
			rd_data_reg <= 8'h00;
	end

	assign rd_data = rd_data_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	AST_SUM_LOW: assert property ( // R1
		bus.rd && bus.addr == `SISB_OFF_GLOBAL |=>
			rd_data[2:0] == {|$past(trx_flags), |$past(sup_flags),
				|$past(sys_flags)})
		else $error("Low summary bits disagree with flags");

	AST_SUM_BANK: assert property ( // R2
		bus.rd && bus.addr == `SISB_OFF_GLOBAL |=>
			rd_data[6:3] == {$past(bank1_fail_pend),
				$past(bank1_wake_pend), $past(bank0_fail_pend),
				|$past(io0_flags)})
		else $error("Bank summary bits disagree with sources");

	AST_SUM_RSVD: assert property ( // R3
		bus.rd && bus.addr == `SISB_OFF_GLOBAL |=> !rd_data[7])
		else $error("Summary bit 7 read as one");

	AST_SYS_RSVD: assert property ( // R4
		(sys_flags & ~`SISB_SYS_IMPL) == 8'h00)
		else $error("Reserved system bit set");

	AST_SUP_RSVD: assert property ( // R5
		sup_flags[7:6] == 2'b00)
		else $error("Reserved supply bit set");

	AST_REGCHG: assert property ( // R6
		sw_seen_reg && switcher_state_bit != sw_prev_reg |=>
			sup_flags[`SISB_SUP_REGCHG_BIT])
		else $error("Regulator change not flagged");

	AST_TRX_RSVD: assert property ( // R7
		trx_flags[7:6] == 2'b00)
		else $error("Reserved transceiver bit set");

	AST_SILENCE: assert property ( // R8
		!can_bus_silent ##1 can_bus_silent[*8] |->
			!trx_flags[`SISB_TRX_SILENCE_BIT] || SIL_LIM < 18'd8 ||
			$past(trx_flags[`SISB_TRX_SILENCE_BIT], 8))
		else $error("Silence flagged before the timeout");

	AST_LIN2: assert property ( // R9
		LIN_COUNT > 1 || !trx_flags[`SISB_TRX_LIN2_BIT])
		else $error("Second LIN wake flag in single-LIN build");

	AST_IO0_SET: assert property ( // R10
		events.io0_evt[0] ##1 1'b1 |-> io0_flags[0])
		else $error("Pin 1 rising edge not flagged at bit 0");

	AST_PWRON: assert property ( // R11
		off_exit |=> sys_flags[`SISB_SYS_PWRON_BIT] && irq)
		else $error("Power-on flag did not raise interrupt");

	AST_WD_RESET: assert property ( // R12
		wd_overflow && sys_flags[`SISB_SYS_WD_BIT] |=>
			wd_reset_req ##1 (!wd_reset_req || $past(wd_overflow)))
		else $error("Repeated watchdog overflow gave no reset");

	AST_W1C: assert property ( // R13
		wr_sys && bus.wdata[1] && !events.sys_evt[1] |=> !sys_flags[1])
		else $error("Write one did not clear flag");

	AST_IRQ_MASK: assert property ( // R14
		(sup_flags & sup_mask_reg) != 8'h00 |-> irq)
		else $error("Enabled supply flag without interrupt");

endmodule : sisb_top

// ---- sim/sisb_host_model.sv ----
// Purpose: Host master that reads and clears the pending flags.
// Assumes: One-cycle strobes, read data in the following cycle only.
// Notes:   Address is inverted while idle (write data too after a write) to expose stale use.
`timescale 1ns/100ps
module sisb_host_model
	import sisb_pkg::*;
(
	input  wire logic          sys_clk, // Clock
	output sisb_bus_req_s      bus,     // Register request
	input  wire logic    [7:0] rd_data  // Read data
);
	// ************
	// Bus cycles
	// ************
	initial bus = '0;

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus <= '{addr: ~a, wdata: 8'h5a, wr: 1'b0, rd: 1'b0};
		// Data stands only in this cycle
		#1 v = rd_data;
	endtask : rd_reg
endmodule : sisb_host_model

// ---- sim/sisb_top_test.sv ----
// Purpose: Self-checking bench for the interrupt status bank.
// Assumes: Short silence count; host model drives the register port.
// Notes:   Second instance is built with a single LIN transceiver.
`timescale 1ns/100ps
`include "sisb_defs.svh"
module sisb_top_test
	import sisb_pkg::*;
;
	localparam int SIL = 20;
	localparam logic [7:0] FA[4] = '{`SISB_OFF_SYS, `SISB_OFF_SUP,
		`SISB_OFF_TRX, `SISB_OFF_IO0};
	localparam logic [7:0] MA[4] = '{`SISB_OFF_SYS_MASK,
		`SISB_OFF_SUP_MASK, `SISB_OFF_TRX_MASK, `SISB_OFF_IO0_MASK};
	// Bits that the raw event pulses may set
	localparam logic [7:0] SETM[4] = '{8'h26, 8'h1f, 8'h2f, 8'hff};
	// Mask bits software can hold; always-enabled sources have none
	localparam logic [7:0] MIMPL[4] = '{
		`SISB_SYS_IMPL & ~`SISB_SYS_ALWAYS, `SISB_SUP_IMPL,
		`SISB_TRX_IMPL, `SISB_IO0_IMPL};

	logic          sys_clk = 1'b0;
	logic          rst;
	sisb_bus_req_s bus;
	logic    [7:0] rd_data, rd_single, d;
	sisb_events_s  events, ev;
	logic          off_exit, wd_overflow, switcher_state_bit;
	logic          can_bus_silent, wd_reset_req, irq;
	logic          bank0_fail_pend, bank1_wake_pend, bank1_fail_pend;
	logic    [7:0] f[4], m[4];
	int            errors = 0;
	int            checked = 0;

	always #2.5 sys_clk = ~sys_clk;

	sisb_top #(.LIN_COUNT(2), .SILENCE_CYCLES(SIL)) dut (
		.sys_clk(sys_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
		.events(events), .off_exit(off_exit), .wd_overflow(wd_overflow),
		.switcher_state_bit(switcher_state_bit),
		.can_bus_silent(can_bus_silent), .bank0_fail_pend(bank0_fail_pend),
		.bank1_wake_pend(bank1_wake_pend), .bank1_fail_pend(bank1_fail_pend),
		.wd_reset_req(wd_reset_req), .irq(irq));

	sisb_top #(.LIN_COUNT(1), .SILENCE_CYCLES(SIL)) dut_single (
		.sys_clk(sys_clk), .rst(rst), .bus(bus), .rd_data(rd_single),
		.events(events), .off_exit(off_exit), .wd_overflow(wd_overflow),
		.switcher_state_bit(switcher_state_bit),
		.can_bus_silent(can_bus_silent), .bank0_fail_pend(bank0_fail_pend),
		.bank1_wake_pend(bank1_wake_pend), .bank1_fail_pend(bank1_fail_pend),
		.wd_reset_req(), .irq());

	sisb_host_model host (.sys_clk(sys_clk), .bus(bus), .rd_data(rd_data));

	// ************
	// Helpers
	// ************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd_reg(a, v);
		check(v, exp);
	endtask : rd_chk

	task automatic pulse(input sisb_events_s v);
		@(posedge sys_clk) events <= v;
		@(posedge sys_clk) events <= '0;
	endtask : pulse

	task automatic done(input string n);
		$display("test %s done", n);
	endtask : done

	function automatic logic [7:0] sum_exp();
		return {1'b0, bank1_fail_pend, bank1_wake_pend, bank0_fail_pend,
			|f[3], |f[2], |f[1], |f[0]};
	endfunction : sum_exp

	function automatic logic [7:0] irq_exp();
		return {7'h00, |(f[0] & (m[0] | `SISB_SYS_ALWAYS)) |
			|(f[1] & m[1]) | |(f[2] & m[2]) | |(f[3] & m[3])};
	endfunction : irq_exp

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// Hang guard, far above the length of the sequence
	initial begin
		repeat (50000) @(posedge sys_clk);
		errors++;
		final_report();
	end

	// ************
	// Sequence
	// ************
	initial begin
		rst = 1'b1;
		events = '0;
		{off_exit, wd_overflow, switcher_state_bit, can_bus_silent} = '0;
		{bank0_fail_pend, bank1_wake_pend, bank1_fail_pend} = '0;
		f = '{default: 8'h00};
		m = '{default: 8'h00};
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		void'($urandom(35));
		for (int i = 0; i < 4; i++) begin
			rd_chk(FA[i], 8'h00);
			rd_chk(MA[i], 8'h00);
		end
		rd_chk(`SISB_OFF_GLOBAL, 8'h00);
		rd_chk(8'h6a, 8'h00);
		check({7'h00, irq}, 8'h00);
		done("reset");

		for (int it = 0; it < 8; it++) begin
			for (int i = 0; i < 4; i++) begin
				m[i] = 8'($urandom);
				host.wr_reg(MA[i], m[i]);
			end
			ev = sisb_events_s'($urandom);
			{bank0_fail_pend, bank1_wake_pend, bank1_fail_pend} <= 3'($urandom);
			pulse(ev);
			for (int i = 0; i < 4; i++) begin
				f[i] |= ev[31 - 8 * i -: 8] & SETM[i];
				rd_chk(FA[i], f[i]);
			end
			host.rd_reg(`SISB_OFF_TRX, d);
			check(rd_single, f[2] & 8'hf7);
			host.wr_reg(`SISB_OFF_GLOBAL, 8'($urandom));
			rd_chk(`SISB_OFF_GLOBAL, sum_exp());
			check({7'h00, irq}, irq_exp());
			for (int i = 0; i < 4; i++) begin
				rd_chk(MA[i], m[i] & MIMPL[i]);
			end
			for (int i = 0; i < 4; i++) begin
				d = 8'($urandom);
				host.wr_reg(FA[i], d);
				f[i] &= ~d;
				rd_chk(FA[i], f[i]);
			end
		end
		done("random");

		for (int i = 0; i < 4; i++) begin
			host.wr_reg(FA[i], 8'hff);
			host.wr_reg(MA[i], 8'h00);
		end
		f = '{default: 8'h00};
		m = '{default: 8'h00};
		// Clear and a new event in the same cycle: the event must win
		fork
			host.wr_reg(`SISB_OFF_IO0, 8'h01);
			pulse(sisb_events_s'(32'h1));
		join
		rd_chk(`SISB_OFF_IO0, 8'h01);
		check({7'h00, irq}, 8'h00);
		// The write lands at the edge the task returns on; look after it
		host.wr_reg(`SISB_OFF_IO0_MASK, 8'h01);
		#1 check({7'h00, irq}, 8'h01);
		host.wr_reg(`SISB_OFF_IO0, 8'h01);
		#1 check({7'h00, irq}, 8'h00);
		done("set_wins");

		@(posedge sys_clk) off_exit <= 1'b1;
		@(posedge sys_clk) off_exit <= 1'b0;
		#1 check({7'h00, irq}, 8'h01);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk) wd_overflow <= 1'b1;
			@(posedge sys_clk) wd_overflow <= 1'b0;
			#1 check({7'h00, wd_reset_req}, {7'h00, 1'(k == 1)});
		end
		@(posedge sys_clk);
		#1 check({7'h00, wd_reset_req}, 8'h00);
		rd_chk(`SISB_OFF_SYS, 8'h11);
		host.wr_reg(`SISB_OFF_SYS, 8'hff);
		#1 check({7'h00, irq}, 8'h00);
		done("power_watchdog");

		@(posedge sys_clk) switcher_state_bit <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd_chk(`SISB_OFF_SUP, 8'h20);
		check({7'h00, irq}, 8'h00);
		host.wr_reg(`SISB_OFF_SUP, 8'h20);
		done("switcher");

		// One edge short of the timeout first, then exactly enough
		for (int k = SIL; k <= SIL + 1; k++) begin
			@(posedge sys_clk) can_bus_silent <= 1'b1;
			repeat (k) @(posedge sys_clk);
			can_bus_silent <= 1'b0;
			rd_chk(`SISB_OFF_TRX, (k > SIL) ? 8'h10 : 8'h00);
		end
		done("silence");
		final_report();
	end
endmodule : sisb_top_test
